// ===== ifc_block.sv
/*
  shifter byte fifo and the interrupt flag, mask and pin control
  logic; assumes one bus access per cycle of sel, timers outside
*/
// Function
// - free-running mode rotates top bit into bit 0 forever, counter off.
// - timer mode: shifter access resets count, shifts 8 bits, 8 strobes.
// - after 8th timer shift: stop, set shifter flag, serial line to level bit.
// - timer mode reload before last time-out keeps shifting without a gap.
// - system-clock mode shifts every clock, second timer left independent.
// - external mode: flag every 8 strobe pulses, shifting continues.
// - interrupt output low while any flag and its mask bit are both 1.
// - flag register bit 7 reads the OR of flag AND mask.
// - one flag register; mask uses same bit positions.
// - port A flags set by pin edges, cleared by port A output access.
// - shifter flag set after eight shifts, cleared by shifter access.
// - port B flags set by pin edges, cleared by port B output access.
// - timer flags set on time-out, cleared by low read or high write.
// - flag register readable; writing 1 clears a flag, 0 leaves it.
// - bit 7 of flags is not writable; it follows the flags.
// - mask write with bit 7 at 0 clears bits written as 1.
// - mask write with bit 7 at 1 sets bits written as 1.
// - mask reads back bits 6 to 0, bit 7 reads 0.
// - pin control holds B serial mode, B edge, A mode, A edge.
// - port A edge select 0 means falling edge, 1 rising edge.
// - control-line input modes; independent modes clear only by writing 1.
// - handshake: line low on port A access, high on next edge input.
// - pulse mode: line low exactly one clock after port A access.
// - manual modes hold control line low or high by lowest mode bit.
// - direction bit 1 selects output modes, two low bits pick which.
`timescale 1ns/1ps
`include "ifc_consts.svh"

module ifc_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign wr_ready = cnt_q != (AW+1)'(D);
  assign rd_valid = cnt_q != '0;
  assign rd_data = mem_q[rp_q];
  assign push = wr_valid & wr_ready;
  assign pop = rd_valid & rd_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ifc_irq_pinctl #(
  parameter int FIFO_D = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input ifc_pkg::ifc_bus_t bus_i,
  output logic [7:0] rd_data_q,
  output logic shift_fifo_ready,
  input wire logic t1_timeout_i,
  input wire logic t2_timeout_i,
  input wire logic t2_tick_i,
  input wire logic port_a_edge_input,
  input wire logic port_a_control_line_i,
  output logic port_a_control_line_o,
  output logic port_a_control_line_oe,
  input wire logic port_b_strobe_line_i,
  output logic port_b_strobe_line_o,
  output logic port_b_strobe_line_oe,
  input wire logic port_b_serial_line_i,
  output logic port_b_serial_line_o,
  output logic port_b_serial_line_oe,
  output logic irq_n_o,
  output logic irq_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] filt_q;
  logic [3:0] prev_q;
  logic [3:0] rise;
  logic [3:0] fall;
  assign pin_raw = {port_b_serial_line_i, port_b_strobe_line_i,
                    port_a_control_line_i, port_a_edge_input};
  assign rise = filt_q & ~prev_q;
  assign fall = ~filt_q & prev_q;
  // a pin change counts once the second and third stages agree
  for (genvar g = 0; g < 4; g++) begin : g_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        s1_q[g] <= 1'b1;
        s2_q[g] <= 1'b1;
        s3_q[g] <= 1'b1;
        filt_q[g] <= 1'b1;
        prev_q[g] <= 1'b1;
      end else begin
        s1_q[g] <= pin_raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          filt_q[g] <= s3_q[g];
        end
        prev_q[g] <= filt_q[g];
      end
    end
  end

  logic [7:0] pinctl_q;
  logic [7:0] aux_q;
  logic [6:0] mask_q;
  logic [6:0] flags_q;
  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic ca2_q;
  logic ser_q;
  logic strobe_q;
  ifc_pkg::ifc_shift_st_t st_q;
  logic wr;
  logic rd;
  logic [7:0] din;
  logic ora_acc;
  logic orb_acc;
  logic sr_acc;
  logic irq;
  assign din = bus_i.wdata;
  assign wr = bus_i.sel & ~bus_i.rd;
  assign rd = bus_i.sel & bus_i.rd;
  assign ora_acc = bus_i.sel & (bus_i.addr == `IFC_OFS_ORA);
  assign orb_acc = bus_i.sel & (bus_i.addr == `IFC_OFS_ORB);
  assign sr_acc = bus_i.sel & (bus_i.addr == `IFC_OFS_SHIFT);

  logic out_en;
  logic [1:0] mode;
  logic tick;
  logic shift_now;
  logic last;
  logic stop_mode;
  logic load;
  logic fifo_valid;
  logic [7:0] fifo_byte;
  assign out_en = aux_q[`IFC_AUX_DIR];
  assign mode = aux_q[`IFC_AUX_MHI:`IFC_AUX_MLO];
  assign stop_mode = (mode == `IFC_SH_TIMER) | (mode == `IFC_SH_SYS);
  always_comb begin
    case (mode)
      `IFC_SH_SYS: tick = 1'b1;
      `IFC_SH_EXT: tick = rise[2];
      default: tick = t2_tick_i;
    endcase
  end
  assign shift_now = out_en & (st_q == ifc_pkg::IFC_RUN) & tick;
  assign last = cnt_q == `IFC_LAST_SHIFT;
  // next byte taken at the last shift
  // free-running takes a new byte at once, the counted modes at a byte boundary
  assign load = out_en & fifo_valid & ((st_q == ifc_pkg::IFC_IDLE) |
                (mode == `IFC_SH_FREE) | (shift_now & last));

  ifc_fifo #(.W(8), .D(FIFO_D)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr_valid(wr & sr_acc),
    .wr_ready(shift_fifo_ready),
    .wr_data(din),
    .rd_valid(fifo_valid),
    .rd_ready(load),
    .rd_data(fifo_byte)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_q <= `IFC_RST_BYTE;
    end else if (load) begin
      sh_q <= fifo_byte;
    end else if (shift_now) begin
      sh_q <= {sh_q[6:0], sh_q[7]};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (sr_acc | load) begin
      cnt_q <= '0;
    end else if (shift_now & (mode != `IFC_SH_FREE)) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ifc_pkg::IFC_IDLE;
    end else begin
      case (st_q)
        ifc_pkg::IFC_IDLE: begin
          // a write runs once its byte leaves the fifo; a read reruns the byte held
          if (load | (out_en & rd & sr_acc)) begin
            st_q <= ifc_pkg::IFC_RUN;
          end
        end
        ifc_pkg::IFC_RUN: begin
          if (~out_en) begin
            st_q <= ifc_pkg::IFC_IDLE;
          end else if (shift_now & last & stop_mode & ~load & ~sr_acc) begin
            st_q <= ifc_pkg::IFC_IDLE;
          end
        end
        default: st_q <= ifc_pkg::IFC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ser_q <= 1'b1;
      strobe_q <= 1'b1;
    end else begin
      // idle level from the pin control level bit
      if (out_en & (st_q == ifc_pkg::IFC_RUN | ~stop_mode)) begin
        ser_q <= sh_q[7];
      end else begin
        ser_q <= pinctl_q[`IFC_PC_B_LVL];
      end
      strobe_q <= ~shift_now;
    end
  end
  assign port_b_serial_line_o = ser_q;
  assign port_b_serial_line_oe = out_en | (pinctl_q[7:6] == 2'h3);
  assign port_b_strobe_line_o = strobe_q;
  assign port_b_strobe_line_oe = out_en & stop_mode;

  // flag positions, shared by the mask
  logic [6:0] set_v;
  logic [6:0] clr_v;
  logic a_edge;
  logic a_in_mode;
  logic b_in_mode;
  assign a_edge = pinctl_q[`IFC_PC_A_EDGE] ? rise[0] : fall[0];
  assign a_in_mode = ~pinctl_q[`IFC_PC_A_OUT];
  assign b_in_mode = ~out_en & ~pinctl_q[`IFC_PC_B_OUT];
  always_comb begin
    set_v[0] = a_in_mode & (pinctl_q[`IFC_PC_A_POL] ? rise[1] : fall[1]);
    set_v[1] = a_edge;
    set_v[2] = shift_now & last & (mode != `IFC_SH_FREE);
    set_v[3] = b_in_mode & (pinctl_q[`IFC_PC_B_POL] ? rise[3] : fall[3]);
    set_v[4] = pinctl_q[`IFC_PC_B_EDGE] ? rise[2] : fall[2];
    set_v[5] = t2_timeout_i;
    set_v[6] = t1_timeout_i;
    // write one clears, bit 7 ignored
    clr_v = (wr & (bus_i.addr == `IFC_OFS_FLAGS)) ? din[6:0] : 7'h00;
    clr_v[0] = clr_v[0] | (ora_acc & ~(a_in_mode & pinctl_q[`IFC_PC_A_IND]));
    clr_v[1] = clr_v[1] | ora_acc;
    clr_v[2] = clr_v[2] | sr_acc;
    clr_v[3] = clr_v[3] | (orb_acc & ~(b_in_mode & pinctl_q[`IFC_PC_B_LVL]));
    clr_v[4] = clr_v[4] | orb_acc;
    clr_v[5] = clr_v[5] | (rd & (bus_i.addr == `IFC_OFS_T2L))
                        | (wr & (bus_i.addr == `IFC_OFS_T2H));
    clr_v[6] = clr_v[6] | (rd & (bus_i.addr == `IFC_OFS_T1L))
                        | (wr & (bus_i.addr == `IFC_OFS_T1H));
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= `IFC_RST_FLAGS;
    end else begin
      flags_q <= (flags_q & ~clr_v) | set_v;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_q <= `IFC_RST_FLAGS;
    end else if (wr & (bus_i.addr == `IFC_OFS_MASK)) begin
      if (din[`IFC_SET_BIT]) begin
        mask_q <= mask_q | din[6:0];
      end else begin
        mask_q <= mask_q & ~din[6:0];
      end
    end
  end

  // pin control and shifter mode storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinctl_q <= `IFC_RST_BYTE;
      aux_q <= `IFC_RST_BYTE;
    end else if (wr) begin
      if (bus_i.addr == `IFC_OFS_PINCTL) begin
        pinctl_q <= din;
      end
      if (bus_i.addr == `IFC_OFS_AUX) begin
        aux_q <= din;
      end
    end
  end

  assign irq = |(flags_q & mask_q);
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ca2_q <= 1'b1;
    end else begin
      case (pinctl_q[2:1])
        `IFC_A_HANDSHAKE: ca2_q <= ora_acc ? 1'b0 : (a_edge ? 1'b1 : ca2_q);
        `IFC_A_PULSE: ca2_q <= ~ora_acc;
        `IFC_A_LOW: ca2_q <= 1'b0;
        default: ca2_q <= 1'b1;
      endcase
    end
  end
  assign port_a_control_line_o = ca2_q;
  assign port_a_control_line_oe = pinctl_q[`IFC_PC_A_OUT];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= `IFC_RST_BYTE;
    end else if (rd) begin
      case (bus_i.addr)
        `IFC_OFS_SHIFT: rd_data_q <= sh_q;
        `IFC_OFS_AUX: rd_data_q <= aux_q;
        `IFC_OFS_PINCTL: rd_data_q <= pinctl_q;
        `IFC_OFS_FLAGS: rd_data_q <= {irq, flags_q};
        `IFC_OFS_MASK: rd_data_q <= {1'b0, mask_q};
        default: rd_data_q <= `IFC_RST_BYTE;
      endcase
    end
  end

  a_irq_follow: assert property ((flags_q[2] & mask_q[2]) |-> irq_n_oe)
    else $error("request not driven for enabled flag");
  a_ifr_bit7: assert property (rd & (bus_i.addr == `IFC_OFS_FLAGS)
    |=> rd_data_q[7] == $past(irq))
    else $error("flag bit 7 does not mirror request");
  a_mask_set: assert property (wr & (bus_i.addr == `IFC_OFS_MASK) & din[7]
    |=> mask_q == ($past(mask_q) | $past(din[6:0])))
    else $error("mask set failed");
  a_mask_clear: assert property (wr & (bus_i.addr == `IFC_OFS_MASK) & ~din[7]
    |=> mask_q == ($past(mask_q) & ~$past(din[6:0])))
    else $error("mask clear failed");
  a_mask_read: assert property (rd & (bus_i.addr == `IFC_OFS_MASK)
    |=> ~rd_data_q[7])
    else $error("mask bit 7 read nonzero");
  a_pulse_one: assert property ((pinctl_q[3:1] == 3'h5) & ora_acc & ~$past(ora_acc)
    ##1 ~ora_acc & (pinctl_q[3:1] == 3'h5) |-> ~ca2_q ##1 ca2_q)
    else $error("pulse not one cycle");
  a_shake_low: assert property ((pinctl_q[3:1] == 3'h4) & ora_acc
    |=> ~ca2_q)
    else $error("handshake not low after access");
  a_sr_flag: assert property (shift_now & last & (mode != `IFC_SH_FREE) & ~sr_acc
    |=> flags_q[2])
    else $error("shifter flag not set");
  a_sr_clear: assert property (sr_acc & ~set_v[2] |=> ~flags_q[2])
    else $error("shifter flag not cleared");
endmodule

// ===== ifc_consts.svh
/*
  register offsets, field positions, reset values and mode codes
  of the interrupt flag and pin control block; definitions only
*/
`ifndef IFC_CONSTS_SVH
`define IFC_CONSTS_SVH
`define IFC_OFS_ORB 4'h0
`define IFC_OFS_ORA 4'h1
`define IFC_OFS_T1L 4'h4
`define IFC_OFS_T1H 4'h5
`define IFC_OFS_T2L 4'h8
`define IFC_OFS_T2H 4'h9
`define IFC_OFS_SHIFT 4'ha
`define IFC_OFS_AUX 4'hb
`define IFC_OFS_PINCTL 4'hc
`define IFC_OFS_FLAGS 4'hd
`define IFC_OFS_MASK 4'he
`define IFC_RST_BYTE 8'h00
`define IFC_RST_FLAGS 7'h00
`define IFC_AUX_DIR 4
`define IFC_AUX_MHI 3
`define IFC_AUX_MLO 2
`define IFC_PC_A_EDGE 0
`define IFC_PC_A_IND 1
`define IFC_PC_A_POL 2
`define IFC_PC_A_OUT 3
`define IFC_PC_B_EDGE 4
`define IFC_PC_B_LVL 5
`define IFC_PC_B_POL 6
`define IFC_PC_B_OUT 7
`define IFC_SET_BIT 7
`define IFC_SH_FREE 2'h0
`define IFC_SH_TIMER 2'h1
`define IFC_SH_SYS 2'h2
`define IFC_SH_EXT 2'h3
`define IFC_A_HANDSHAKE 2'h0
`define IFC_A_PULSE 2'h1
`define IFC_A_LOW 2'h2
`define IFC_A_HIGH 2'h3
`define IFC_LAST_SHIFT 3'h7
`endif

// ===== ifc_pkg.sv
/*
  types shared by the interrupt flag and pin control block;
  assumes the constants header supplies all numbers
*/
package ifc_pkg;
  typedef struct packed {
    logic sel;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ifc_bus_t;
  typedef enum logic [1:0] {
    IFC_IDLE = 2'b01,
    IFC_RUN = 2'b10
  } ifc_shift_st_t;
endpackage

// ===== ifc_periph.sv
/*
  peripheral model on the control and strobe lines of the block;
  assumes the bench calls its tasks and resolves nothing else
*/
`timescale 1ns/1ps
module ifc_periph (
  input wire logic clk,
  input wire logic a_ctl_o,
  input wire logic a_ctl_oe,
  input wire logic b_stb_o,
  input wire logic b_stb_oe,
  input wire logic b_ser_o,
  input wire logic b_ser_oe,
  output logic a_ctl_w,
  output logic b_stb_w,
  output logic b_ser_w,
  output logic a_edge,
  output logic [7:0] stb_falls
);
  logic a_ctl_d;
  logic b_stb_d;
  logic b_ser_d;
  initial begin
    a_ctl_d = 1'b1;
    b_ser_d = 1'b1;
    b_stb_d = 1'b1;
    a_edge = 1'b1;
    stb_falls = 8'h00;
  end
  // wire level: device drives when enabled, else the peer
  assign a_ctl_w = a_ctl_oe ? a_ctl_o : a_ctl_d;
  assign b_stb_w = b_stb_oe ? b_stb_o : b_stb_d;
  assign b_ser_w = b_ser_oe ? b_ser_o : b_ser_d;
  always @(negedge b_stb_w) begin
    stb_falls <= stb_falls + 8'h01;
  end
  task set_edge(input logic v);
    @(posedge clk);
    a_edge <= v;
  endtask
  task set_ctl(input logic v);
    @(posedge clk);
    a_ctl_d <= v;
  endtask
  task set_ser(input logic v);
    @(posedge clk);
    b_ser_d <= v;
  endtask
  task pulse_strobe(input int n);
    repeat (n) begin
      @(posedge clk);
      b_stb_d <= 1'b0;
      repeat (2) @(posedge clk);
      b_stb_d <= 1'b1;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

// ===== ifc_irq_pinctl_tb.sv
/*
  self-checking bench of the interrupt flag and pin control block;
  assumes the constants header and the peripheral model
*/
`timescale 1ns/1ps
`include "ifc_consts.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ifc_irq_pinctl_tb;
  logic clk;
  logic sys_rst;
  ifc_pkg::ifc_bus_t bus;
  logic [7:0] rdat;
  logic t1;
  logic t2;
  logic tk;
  logic a_edge, a_ctl_w, b_stb_w, b_ser_w;
  logic a_ctl_o, a_ctl_oe, b_stb_o, b_stb_oe, b_ser_o, b_ser_oe, irq_o, irq_oe, frdy;
  logic [7:0] falls;
  logic [7:0] rv;
  logic [7:0] n0;
  int miscompares;
  int check_count;
  int n;
  ifc_irq_pinctl #(.FIFO_D(16)) u_dut (.clk(clk), .sys_rst(sys_rst), .bus_i(bus),
    .rd_data_q(rdat), .shift_fifo_ready(frdy), .t1_timeout_i(t1), .t2_timeout_i(t2),
    .t2_tick_i(tk), .port_a_edge_input(a_edge), .port_a_control_line_i(a_ctl_w),
    .port_a_control_line_o(a_ctl_o), .port_a_control_line_oe(a_ctl_oe),
    .port_b_strobe_line_i(b_stb_w), .port_b_strobe_line_o(b_stb_o),
    .port_b_strobe_line_oe(b_stb_oe), .port_b_serial_line_i(b_ser_w),
    .port_b_serial_line_o(b_ser_o), .port_b_serial_line_oe(b_ser_oe),
    .irq_n_o(irq_o), .irq_n_oe(irq_oe));
  ifc_periph u_peer (.clk(clk), .a_ctl_o(a_ctl_o), .a_ctl_oe(a_ctl_oe), .b_stb_o(b_stb_o),
    .b_stb_oe(b_stb_oe), .b_ser_o(b_ser_o), .b_ser_oe(b_ser_oe), .a_ctl_w(a_ctl_w),
    .b_stb_w(b_stb_w), .b_ser_w(b_ser_w), .a_edge(a_edge), .stb_falls(falls));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one bus access; read data is taken after the sampling edge
  task acc(input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{sel: 1'b1, rd: r, addr: a, wdata: d};
    @(posedge clk);
    bus <= '{default: '0};
    #1 rv = rdat;
  endtask
  task pulse(input int k);
    @(posedge clk);
    case (k)
      0: t1 <= 1'b1;
      1: t2 <= 1'b1;
      default: tk <= 1'b1;
    endcase
    @(posedge clk);
    t1 <= 1'b0;
    t2 <= 1'b0;
    tk <= 1'b0;
  endtask
  task ticks(input int k);
    repeat (k) begin
      pulse(2);
      repeat (3) @(posedge clk);
    end
  endtask
  task t_reset;
    acc(1'b1, `IFC_OFS_MASK, 8'h00);
    `CHK("mask", 8'h00, rv)
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("flags", 8'h00, rv)
    acc(1'b1, `IFC_OFS_PINCTL, 8'h00);
    `CHK("pinctl", 8'h00, rv)
    `CHK("irq pin", 2'b00, {irq_o, irq_oe})
    `CHK("fifo rdy", 1'b1, frdy)
    $display("test reset done");
  endtask
  task t_mask;
    acc(1'b0, `IFC_OFS_MASK, 8'hff);
    acc(1'b1, `IFC_OFS_MASK, 8'h00);
    `CHK("mask set", 8'h7f, rv)
    acc(1'b0, `IFC_OFS_MASK, 8'h05);
    acc(1'b1, `IFC_OFS_MASK, 8'h00);
    `CHK("mask clr", 8'h7a, rv)
    acc(1'b0, `IFC_OFS_MASK, 8'h80);
    acc(1'b1, `IFC_OFS_MASK, 8'h00);
    `CHK("mask keep", 8'h7a, rv)
    acc(1'b0, `IFC_OFS_MASK, 8'hff);
    $display("test mask done");
  endtask
  task t_timers;
    pulse(0);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("t1 flag", 8'hc0, rv)
    `CHK("irq on", 2'b01, {irq_o, irq_oe})
    acc(1'b0, `IFC_OFS_MASK, 8'h40);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("masked", 8'h40, rv)
    `CHK("irq off", 2'b00, {irq_o, irq_oe})
    acc(1'b0, `IFC_OFS_MASK, 8'hff);
    acc(1'b0, `IFC_OFS_FLAGS, 8'ha0);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("w1 bit7", 8'hc0, rv)
    acc(1'b1, `IFC_OFS_T1L, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("t1l clr", 8'h00, rv)
    pulse(1);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("t2 flag", 8'ha0, rv)
    acc(1'b0, `IFC_OFS_T2H, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("t2h clr", 8'h00, rv)
    pulse(0);
    acc(1'b0, `IFC_OFS_FLAGS, 8'h40);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("w1 clr", 8'h00, rv)
    $display("test timers done");
  endtask
  task t_pins;
    u_peer.set_edge(1'b0);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("fall flag", 1'b1, rv[1])
    acc(1'b1, `IFC_OFS_ORA, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ora clr", 1'b0, rv[1])
    acc(1'b0, `IFC_OFS_PINCTL, 8'h01);
    u_peer.set_edge(1'b1);
    repeat (8) @(posedge clk);
    acc(1'b0, `IFC_OFS_ORA, 8'h00);
    u_peer.set_edge(1'b0);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("pos only", 1'b0, rv[1])
    acc(1'b0, `IFC_OFS_PINCTL, 8'h00);
    u_peer.set_ctl(1'b0);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ctl flag", 1'b1, rv[0])
    acc(1'b0, `IFC_OFS_ORA, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ctl clr", 1'b0, rv[0])
    acc(1'b0, `IFC_OFS_PINCTL, 8'h02);
    u_peer.set_ctl(1'b1);
    repeat (8) @(posedge clk);
    u_peer.set_ctl(1'b0);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_ORA, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("indep keep", 1'b1, rv[0])
    acc(1'b0, `IFC_OFS_FLAGS, 8'h01);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("indep w1", 1'b0, rv[0])
    $display("test pins done");
  endtask
  task t_ctl_out;
    acc(1'b0, `IFC_OFS_PINCTL, 8'h0a);
    acc(1'b0, `IFC_OFS_ORA, 8'h00);
    n = 0;
    for (int i = 0; i < 8; i++) begin
      if (a_ctl_o === 1'b0) n++;
      @(posedge clk);
      #1;
    end
    `CHK("pulse len", 1, n)
    acc(1'b0, `IFC_OFS_PINCTL, 8'h0c);
    @(posedge clk);
    #1;
    `CHK("man low", 2'b01, {a_ctl_o, a_ctl_oe})
    acc(1'b0, `IFC_OFS_PINCTL, 8'h0e);
    @(posedge clk);
    #1;
    `CHK("man high", 2'b11, {a_ctl_o, a_ctl_oe})
    acc(1'b0, `IFC_OFS_PINCTL, 8'h08);
    u_peer.set_edge(1'b1);
    repeat (8) @(posedge clk);
    acc(1'b0, `IFC_OFS_ORA, 8'h00);
    repeat (4) @(posedge clk);
    `CHK("hs low", 1'b0, a_ctl_w)
    u_peer.set_edge(1'b0);
    repeat (8) @(posedge clk);
    `CHK("hs high", 1'b1, a_ctl_w)
    $display("test ctl_out done");
  endtask
  task t_portb;
    u_peer.pulse_strobe(1);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("strobe flag", 1'b1, rv[4])
    u_peer.set_ser(1'b0);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("serial flag", 1'b1, rv[3])
    acc(1'b0, `IFC_OFS_ORB, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("orb clr", 2'b00, rv[4:3])
    $display("test portb done");
  endtask
  task t_shift_timer;
    acc(1'b0, `IFC_OFS_AUX, 8'h14);
    acc(1'b0, `IFC_OFS_SHIFT, 8'ha5);
    repeat (3) @(posedge clk);
    n0 = falls;
    ticks(7);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("no flag 7", 1'b0, rv[2])
    ticks(1);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("flag 8", 1'b1, rv[2])
    `CHK("pulses", 8'h08, falls - n0)
    ticks(2);
    `CHK("stopped", 8'h08, falls - n0)
    `CHK("idle lvl", 1'b0, b_ser_w)
    acc(1'b1, `IFC_OFS_SHIFT, 8'h00);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("sh clr", 1'b0, rv[2])
    acc(1'b0, `IFC_OFS_SHIFT, 8'h3c);
    acc(1'b0, `IFC_OFS_SHIFT, 8'hc3);
    repeat (3) @(posedge clk);
    n0 = falls;
    ticks(16);
    `CHK("reload", 8'h10, falls - n0)
    $display("test shift_timer done");
  endtask
  task t_shift_ext;
    acc(1'b0, `IFC_OFS_AUX, 8'h1c);
    acc(1'b0, `IFC_OFS_SHIFT, 8'h5a);
    u_peer.pulse_strobe(7);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ext 7", 1'b0, rv[2])
    u_peer.pulse_strobe(1);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ext 8", 1'b1, rv[2])
    acc(1'b0, `IFC_OFS_SHIFT, 8'h11);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ext clr", 1'b0, rv[2])
    u_peer.pulse_strobe(8);
    repeat (8) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("ext again", 1'b1, rv[2])
    $display("test shift_ext done");
  endtask
  task t_shift_sys;
    acc(1'b0, `IFC_OFS_AUX, 8'h18);
    repeat (12) @(posedge clk);
    acc(1'b0, `IFC_OFS_SHIFT, 8'h96);
    repeat (12) @(posedge clk);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("sys flag", 1'b1, rv[2])
    `CHK("sys oe", 2'b11, {b_stb_oe, b_ser_oe})
    acc(1'b1, `IFC_OFS_SHIFT, 8'h00);
    `CHK("sys rot", 8'h96, rv)
    $display("test shift_sys done");
  endtask
  task t_shift_free;
    acc(1'b0, `IFC_OFS_AUX, 8'h10);
    acc(1'b0, `IFC_OFS_SHIFT, 8'h81);
    ticks(12);
    acc(1'b1, `IFC_OFS_FLAGS, 8'h00);
    `CHK("free flag", 1'b0, rv[2])
    `CHK("free stb oe", 1'b0, b_stb_oe)
    acc(1'b1, `IFC_OFS_SHIFT, 8'h00);
    `CHK("free rot", 8'h18, rv)
    $display("test shift_free done");
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    bus = '{default: '0};
    t1 = 1'b0;
    t2 = 1'b0;
    tk = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_mask();
    t_timers();
    t_pins();
    t_ctl_out();
    t_portb();
    t_shift_timer();
    t_shift_ext();
    t_shift_sys();
    t_shift_free();
    results();
  end
endmodule
